// ---- rtl/rgb_input_regs.svh ----
// timing counts and field positions of the rgb display input
`ifndef RGB_INPUT_REGS_SVH
`define RGB_INPUT_REGS_SVH
`define BLUE_LSB           0
`define GREEN_LSB          6
`define RED_LSB            12
`define CHAN_W             6
`define PIX_W              18
`define RED_PIN            20
`define GREEN_PIN          10
`define BLUE_PIN           0
`define CTL_IDLE           4'hB
`define DLY_IDLE           3'h3
`define ACTIVE_PIXELS      9'h0F0
`define ACTIVE_LINES       9'h140
`define GAMMA_SHIFT        3'h2
`define STBY_FRAMES        5'h14
`define WAKE_FRAMES        5'h01
`endif

// ---- rtl/rgb_input_pkg.sv ----
// types of the rgb display input
package rgb_input_pkg;
    typedef enum logic [3:0] {
        ST_WAIT_SYNC = 4'h1,
        ST_RUN       = 4'h2,
        ST_STBY_IN   = 4'h4,
        ST_STANDBY   = 4'h8
    } pwr_state_type;
endpackage

// ---- rtl/rgb_display_input.sv ----
// receiving logic of a parallel 6-bit rgb pixel input
`timescale 1ns/10ps
`include "rgb_input_regs.svh"
// Function
// - horizontal sync is active low; low level marks line start.
// - vertical sync is active low; low level marks frame start.
// - low reset input resets all internal logic.
// - blue is data bits 0..5, bit 0 least significant.
// - green is data bits 10..15, bit 10 least significant.
// - red is data bits 20..25, bit 20 least significant.
// - zero code is black; module applies its own gamma conversion.
// - pixel data is valid only while data enable is high.
// - standby input high means normal, low means standby.
// - operation starts only after dot clock and vertical sync arrive.
module rgb_display_input (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        i_hsync_n,
    input  wire logic        i_vsync_n,
    input  wire logic        i_de,
    input  wire logic [25:0] i_data,
    input  wire logic        i_standby_n_in,
    input  wire logic        i_pix_ready,
    output logic             o_pix_valid,
    output logic [17:0]      o_pix_data,
    output logic             o_line_start,
    output logic             o_frame_start,
    output logic [8:0]       o_line_count,
    output logic [8:0]       o_pixel_count,
    output logic             o_display_on,
    output logic             o_standby,
    output logic             o_overflow
);
    // pins cross two flops before use; a third stage keeps syncs in step with data
    logic [3:0]  ctl1_r, ctl2_r, ctl3_r, ctl1_nxt, ctl2_nxt, ctl3_nxt;
    logic [2:0]  dly_r, dly_nxt;
    logic [17:0] dat1_r, dat2_r, dat3_r, dat1_nxt, dat2_nxt, dat3_nxt;
    logic        hs_n, vs_n, de, stby_n, hs_n_d, vs_n_d, de_d;
    logic [17:0] pix_in;
    rgb_input_pkg::pwr_state_type st_r, st_nxt;
    logic [4:0]  frm_r, frm_nxt;
    logic [8:0]  line_r, line_nxt, px_r, px_nxt;
    logic        ls_r, ls_nxt, fs_r, fs_nxt, ovf_r, ovf_nxt, seen_r, seen_nxt;
    // two-entry buffer
    logic [17:0] buf_r [2];
    logic [17:0] buf_nxt [2];
    logic [1:0]  cnt_r, cnt_nxt;
    logic        rd_r, rd_nxt, wr_r, wr_nxt;
    logic        push, pop, accept;
    // output copies so every port leaves from its own flop
    logic        pv_r, pv_nxt, on_r, on_nxt, sb_r, sb_nxt;
    logic [17:0] pd_r, pd_nxt;

    function automatic logic [5:0] gamma(input logic [5:0] c);
        logic [11:0] sq;
        // square of a 6-bit code needs twelve bits
        sq = ({6'h00, c} * {6'h00, c}) >> 6;
        // cheap square-law curve, zero stays black
        gamma = 6'(({6'h00, c} + sq) >> 1);
    endfunction

    assign hs_n   = ctl3_r[0];
    assign vs_n   = ctl3_r[1];
    assign de     = ctl3_r[2];
    assign stby_n = ctl2_r[3];
    assign hs_n_d = dly_r[0];
    assign vs_n_d = dly_r[1];
    assign de_d   = dly_r[2];
    always_comb begin
        ctl1_nxt = {i_standby_n_in, i_de, i_vsync_n, i_hsync_n};
        ctl2_nxt = ctl1_r;
        ctl3_nxt = ctl2_r;
        dly_nxt  = ctl3_r[2:0];
        dat1_nxt = {i_data[`RED_PIN+:`CHAN_W], i_data[`GREEN_PIN+:`CHAN_W],
                    i_data[`BLUE_PIN+:`CHAN_W]};
        dat2_nxt = dat1_r;
        dat3_nxt = dat2_r;
    end
    // pixel field of the third data stage
    assign pix_in = {gamma(dat3_r[`RED_LSB+:`CHAN_W]),
                     gamma(dat3_r[`GREEN_LSB+:`CHAN_W]),
                     gamma(dat3_r[`BLUE_LSB+:`CHAN_W])};

    always_comb begin
        st_nxt   = st_r;
        frm_nxt  = frm_r;
        line_nxt = line_r;
        px_nxt   = px_r;
        seen_nxt = seen_r;
        ls_nxt   = !hs_n && hs_n_d;
        fs_nxt   = !vs_n && vs_n_d;
        ovf_nxt  = ovf_r;
        if (fs_nxt) begin
            line_nxt = 9'h000;
        end else if (de_d && !de && line_r != 9'h1FF) begin
            line_nxt = line_r + 9'h001;
        end
        if (!de) begin
            px_nxt = 9'h000;
        end else if (px_r != 9'h1FF) begin
            px_nxt = px_r + 9'h001;
        end
        case (st_r)
            rgb_input_pkg::ST_WAIT_SYNC: begin
                // counters need a live vsync before pixels are taken
                if (fs_nxt && stby_n) begin
                    st_nxt = rgb_input_pkg::ST_RUN;
                end
            end
            rgb_input_pkg::ST_RUN: begin
                if (!stby_n) begin
                    st_nxt  = rgb_input_pkg::ST_STBY_IN;
                    frm_nxt = 5'h00;
                end
            end
            rgb_input_pkg::ST_STBY_IN: begin
                if (stby_n) begin
                    st_nxt = rgb_input_pkg::ST_WAIT_SYNC;
                end else if (fs_nxt) begin
                    frm_nxt = frm_r + 5'h01;
                    if (frm_r + 5'h01 >= `STBY_FRAMES) begin
                        st_nxt = rgb_input_pkg::ST_STANDBY;
                    end
                end
            end
            rgb_input_pkg::ST_STANDBY: begin
                if (stby_n) begin
                    st_nxt = rgb_input_pkg::ST_WAIT_SYNC;
                end
            end
            default: st_nxt = rgb_input_pkg::ST_WAIT_SYNC;
        endcase
        if (push && !accept) begin
            ovf_nxt = 1'b1;
        end
        seen_nxt = seen_r | fs_nxt;
        on_nxt   = st_nxt == rgb_input_pkg::ST_RUN;
        sb_nxt   = st_nxt == rgb_input_pkg::ST_STANDBY;
    end

    // pixels taken only with enable high while running
    assign push   = de && st_r == rgb_input_pkg::ST_RUN
                    && px_r < `ACTIVE_PIXELS;
    // a full buffer still takes a word when one leaves in the same cycle
    assign accept = cnt_r != 2'h2 || pop;
    assign pop    = o_pix_valid && i_pix_ready;

    always_comb begin
        buf_nxt[0] = buf_r[0];
        buf_nxt[1] = buf_r[1];
        cnt_nxt    = cnt_r;
        rd_nxt     = rd_r;
        wr_nxt     = wr_r;
        if (push && accept) begin
            buf_nxt[wr_r] = pix_in;
            wr_nxt        = !wr_r;
        end
        if (pop) begin
            rd_nxt = !rd_r;
        end
        cnt_nxt = cnt_r + {1'b0, push && accept} - {1'b0, pop};
        pv_nxt  = cnt_nxt != 2'h0;
        pd_nxt  = buf_nxt[rd_nxt];
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            ctl1_r <= `CTL_IDLE;
            ctl2_r <= `CTL_IDLE;
            ctl3_r <= `CTL_IDLE;
            dly_r  <= `DLY_IDLE;
            dat1_r <= 18'h00000;
            dat2_r <= 18'h00000;
            dat3_r <= 18'h00000;
            st_r   <= rgb_input_pkg::ST_WAIT_SYNC;
            frm_r  <= 5'h00;
            line_r <= 9'h000;
            px_r   <= 9'h000;
            ls_r   <= 1'b0;
            fs_r   <= 1'b0;
            ovf_r  <= 1'b0;
            seen_r <= 1'b0;
            buf_r[0] <= 18'h00000;
            buf_r[1] <= 18'h00000;
            cnt_r  <= 2'h0;
            rd_r   <= 1'b0;
            wr_r   <= 1'b0;
            pv_r   <= 1'b0;
            pd_r   <= 18'h00000;
            on_r   <= 1'b0;
            sb_r   <= 1'b0;
        end else begin
            ctl1_r <= ctl1_nxt;
            ctl2_r <= ctl2_nxt;
            ctl3_r <= ctl3_nxt;
            dly_r  <= dly_nxt;
            dat1_r <= dat1_nxt;
            dat2_r <= dat2_nxt;
            dat3_r <= dat3_nxt;
            st_r   <= st_nxt;
            frm_r  <= frm_nxt;
            line_r <= line_nxt;
            px_r   <= px_nxt;
            ls_r   <= ls_nxt;
            fs_r   <= fs_nxt;
            ovf_r  <= ovf_nxt;
            seen_r <= seen_nxt;
            buf_r[0] <= buf_nxt[0];
            buf_r[1] <= buf_nxt[1];
            cnt_r  <= cnt_nxt;
            rd_r   <= rd_nxt;
            wr_r   <= wr_nxt;
            pv_r   <= pv_nxt;
            pd_r   <= pd_nxt;
            on_r   <= on_nxt;
            sb_r   <= sb_nxt;
        end
    end

    // outputs straight from flops
    assign o_pix_valid   = pv_r;
    assign o_pix_data    = pd_r;
    assign o_line_start  = ls_r;
    assign o_frame_start = fs_r;
    assign o_line_count  = line_r;
    assign o_pixel_count = px_r;
    assign o_display_on  = on_r;
    assign o_standby     = sb_r;
    assign o_overflow    = ovf_r;
endmodule // rgb_display_input

// ---- tb/rgb_display_input_properties.sv ----
// port assertions of the rgb display input
`timescale 1ns/10ps
module rgb_display_input_properties (
    input wire logic        i_clk_sys, i_rst_b, i_hsync_n, i_vsync_n, i_de,
    input wire logic        i_standby_n_in, i_pix_ready, o_pix_valid, o_line_start,
    input wire logic        o_frame_start, o_display_on, o_standby, o_overflow,
    input wire logic [17:0] o_pix_data,
    input wire logic [8:0]  o_line_count, o_pixel_count
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    property p_reset;
        disable iff (1'b0) !i_rst_b |=> {o_pix_valid, o_line_start, o_frame_start, o_display_on,
            o_standby, o_overflow, o_pix_data, o_line_count, o_pixel_count} == 42'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared");
    property p_frame; $fell(i_vsync_n) |-> ##4 o_frame_start; endproperty
    a_frame: assert property (p_frame) else $error("frame pulse missing");
    property p_fs_once; o_frame_start |=> !o_frame_start; endproperty
    a_fs_once: assert property (p_fs_once) else $error("frame pulse too long");
    property p_line; $fell(i_hsync_n) |-> ##4 o_line_start; endproperty
    a_line: assert property (p_line) else $error("line pulse missing");
    property p_hold; o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_data); endproperty
    a_hold: assert property (p_hold) else $error("pixel lost in stall");
    // six samples cover the three input stages plus the count register
    property p_idle; !i_de [*6] |-> o_pixel_count == 9'h000; endproperty
    a_idle: assert property (p_idle) else $error("count with enable low");
    property p_src; $rose(o_pix_valid) |-> $past(i_de, 4) || $past(i_de, 5); endproperty
    a_src: assert property (p_src) else $error("pixel without enable");
    property p_stby; !i_standby_n_in [*3] |=> !o_display_on; endproperty
    a_stby: assert property (p_stby) else $error("display on in standby");
    c_frame: cover property (o_frame_start);
    c_pop: cover property (o_pix_valid && i_pix_ready);
    c_stby: cover property (o_standby);
endmodule // rgb_display_input_properties
bind rgb_display_input rgb_display_input_properties u_props (.i_clk_sys, .i_rst_b, .i_hsync_n,
    .i_vsync_n, .i_de, .i_standby_n_in, .i_pix_ready, .o_pix_valid, .o_line_start,
    .o_frame_start, .o_display_on, .o_standby, .o_overflow, .o_pix_data, .o_line_count,
    .o_pixel_count);

// ---- tb/rgb_controller_model.sv ----
// display controller model driving rgb pixel timing
`timescale 1ns/10ps
module rgb_controller_model #(
    parameter int LINE  = 287,
    parameter int LINES = 325,
    parameter int ACT   = 320
) (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    output logic             o_hsync_n,
    output logic             o_vsync_n,
    output logic             o_de,
    output logic [25:0]      o_data
);
    int         h = 0;
    int         v = 0;
    logic [3:0] t = 4'h0;
    initial {o_hsync_n, o_vsync_n, o_de, o_data} = {3'h6, 26'h0};
    always @(negedge i_clk) begin
        t <= t + 4'h1;
        h <= (!i_go || h == LINE - 1) ? 0 : h + 1;
        if (!i_go)
            v <= 0;
        else if (h == LINE - 1)
            v <= (v == LINES - 1) ? 0 : v + 1;
        o_hsync_n <= !(i_go && h == 0);
        o_vsync_n <= !(i_go && v == 0);
        o_de <= i_go && v >= 3 && v < 3 + ACT && h >= 3 && h < 243;
        // unused bits toggle so the receiver cannot lean on them
        o_data <= i_go ? {v[5:0], t, ~h[5:0], t, h[5:0]} : 26'h0;
    end
endmodule // rgb_controller_model

// ---- tb/test_rgb_display_input.sv ----
// self-checking bench of the rgb display input
`timescale 1ns/10ps
module test_rgb_display_input;
    logic        clk = 1'b0, rst_b = 1'b0, go = 1'b0, stby_n = 1'b1, rdy = 1'b1, rdy_en = 1'b1;
    logic        sb_on = 1'b0, hs_n, vs_n, de, pv, ls, fs, on, sb, ovf;
    logic [25:0] dat;
    logic [17:0] pd, ex;
    logic [8:0]  lc, pc;
    logic [17:0] q[$];
    int          n_fail = 0, n_compared = 0, n_pix = 0, n_ls = 0, n_fs = 0, k, c0;
    // short frames keep twenty standby frames within the run
    rgb_controller_model #(.LINE(250), .LINES(8), .ACT(3)) u_rgb_controller_model (.i_clk(clk),
        .i_go(go), .o_hsync_n(hs_n), .o_vsync_n(vs_n), .o_de(de), .o_data(dat));
    rgb_display_input u_rgb_display_input (.i_clk_sys(clk), .i_rst_b(rst_b), .i_hsync_n(hs_n),
        .i_vsync_n(vs_n), .i_de(de), .i_data(dat), .i_standby_n_in(stby_n), .i_pix_ready(rdy),
        .o_pix_valid(pv), .o_pix_data(pd), .o_line_start(ls), .o_frame_start(fs),
        .o_line_count(lc), .o_pixel_count(pc), .o_display_on(on), .o_standby(sb),
        .o_overflow(ovf));
    function automatic logic [5:0] gam(input logic [5:0] c);
        return 6'((12'(c) + 12'(c) * 12'(c) / 12'h040) >> 1);
    endfunction
    task automatic cmp(input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_on(ref logic s, input int lim);
        for (k = 0; k < lim && s !== 1'b1; k++) @(negedge clk);
    endtask
    initial forever #4 clk = ~clk;
    initial begin
        #600000;
        n_fail++;
        give_verdict();
    end
    always @(posedge clk) begin
        n_ls += int'(ls);
        n_fs += int'(fs);
        if (sb_on && de) q.push_back({gam(dat[25:20]), gam(dat[15:10]), gam(dat[5:0])});
        if (sb_on && pv && rdy) begin
            n_pix++;
            ex = q.size() ? q.pop_front() : 18'h3FFFF;
            cmp({6'h0, ex}, {6'h0, pd});
        end
    end
    // one stall per active line: the two-entry buffer must absorb it
    always @(negedge clk) rdy <= rdy_en && pc !== 9'h064;
    task automatic t_reset();
        rst_b = 1'b0;
        repeat (16) @(negedge clk);
        cmp(24'h0, {pv, ls, fs, on, sb, ovf, lc, pc});
        cmp(24'h0, {6'h0, pd});
        rst_b = 1'b1;
        $display("reset done");
    endtask
    task automatic t_stream();
        repeat (100) @(negedge clk);
        cmp(24'h0, {22'h0, on, pv});
        go <= 1'b1;
        wait_on(fs, 600);
        cmp(24'h1, {23'h0, fs});
        sb_on = 1'b1;
        c0 = n_ls;
        repeat (2) begin
            @(negedge clk);
            wait_on(fs, 3000);
        end
        cmp(24'h10, 24'(n_ls - c0));
        cmp(24'h0005A0, 24'(n_pix));
        cmp(24'h1, {23'h0, on});
        // six lines into the frame all three active lines have ended
        repeat (1500) @(negedge clk);
        cmp(24'h3, {15'h0, lc});
        $display("stream done");
    endtask
    task automatic t_overflow();
        sb_on = 1'b0;
        rdy_en = 1'b0;
        wait_on(ovf, 3000);
        rdy_en = 1'b1;
        repeat (20) @(negedge clk);
        cmp(24'h1, {23'h0, ovf});
        $display("overflow done");
    endtask
    task automatic t_standby();
        stby_n = 1'b0;
        c0 = n_fs;
        wait_on(sb, 50000);
        repeat (2) @(negedge clk);
        cmp(24'h14, 24'(n_fs - c0));
        cmp(24'h1, {22'h0, on, sb});
        stby_n = 1'b1;
        wait_on(on, 5000);
        cmp(24'h2, {22'h0, on, sb});
        $display("standby done");
    endtask
    initial begin
        t_reset();
        t_stream();
        t_overflow();
        t_standby();
        t_reset();
        give_verdict();
    end
endmodule // test_rgb_display_input
